// File: design/adcps_device.sv
// Converter end: trigger-driven power sequencing and the framed serial port.
// Shift logic runs on the link clock; sequencing runs on sys_clk_i.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1 - Trigger low at conversion end: power down
// RULE2 - Trigger rise while down starts power-up
// RULE3 - Fall converts; result latched, then power-down
// RULE4 - Early fall waits out remaining power-up
// RULE5 - Late fall starts conversion immediately
// RULE6 - Port enabled first sclk rise after read sync
// RULE7 - Early read returns previous conversion result
// RULE8 - Host waits conversion time before current read
// RULE9 - Serial port works while powered down
// RULE10 - Works with free-running or gated clock
// RULE11 - Frame sync edges reset bit counters
// RULE12 - Extra clocks ignored after count completes
// RULE13 - Output drives from first rise, each rise
// RULE14 - Output released on 11th rise
// RULE15 - Input sampled on falling edges after sync
// RULE16 - Control updated on 13th rising edge
// RULE17 - No shifting without active frame sync edge
// RULE18 - Three-wire tie only with gated clock
// RULE19 - Trigger high at end: stay powered
// RULE20 - Words move most significant bit first
// RULE21 - Result left-justified straight binary in frame
// RULE22 - Intervals counted on internal clock, parameterised
module adcps_device #(
    parameter int PWRUP_CYCLES = adcps_pkg::PWRUP_CYCLES,
    parameter int CONV_CYCLES = adcps_pkg::CONV_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link to host
    adcps_link_if.device lnk,
    // Converter user side
    input wire logic [adcps_pkg::RESULT_W-1:0] sample_i,
    output logic [adcps_pkg::RESULT_W-1:0] result_o,
    output logic eoc_o,
    output logic powered_o,
    output logic converting_o,
    output logic [adcps_pkg::CTRL_W-1:0] ctrl_o,
    output logic ctrl_upd_o
);
    localparam int TMR_W = $clog2(PWRUP_CYCLES + CONV_CYCLES + 1);
    localparam logic [TMR_W-1:0] PU_LOAD = TMR_W'(PWRUP_CYCLES - 1);
    localparam logic [TMR_W-1:0] CV_LOAD = TMR_W'(CONV_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain: read shifter
    logic [adcps_pkg::EDGE_CNT_W-1:0] rd_cnt;
    logic [adcps_pkg::EDGE_CNT_W-1:0] next_rd_cnt;
    logic [adcps_pkg::FRAME_W-1:0] rd_sh;
    logic [adcps_pkg::FRAME_W-1:0] next_rd_sh;
    logic [adcps_pkg::FRAME_W-1:0] frame;
    logic dout_q;
    logic next_dout;
    logic oe_q;
    logic next_oe;
    logic [adcps_pkg::RESULT_W-1:0] result_q;

    // Result frozen in sys domain while the read sync is high
    assign frame = {result_q, {adcps_pkg::RESULT_LSB{1'b0}}}; // see RULE21

    // Counter idles at zero until sync; saturates at the release edge
    always_comb
    begin
        next_rd_cnt = rd_cnt;
        next_rd_sh = rd_sh;
        next_dout = dout_q;
        next_oe = oe_q;
        if (rd_cnt == '0)
        begin
            next_rd_cnt = rd_cnt + 1'b1; // see RULE6
            next_dout = frame[adcps_pkg::FRAME_W-1]; // see RULE13
            next_rd_sh = {frame[adcps_pkg::FRAME_W-2:0], 1'b0}; // see RULE20
            next_oe = 1'b1;
        end
        else if (rd_cnt < adcps_pkg::READ_LAST_EDGE) // see RULE12
        begin
            next_rd_cnt = rd_cnt + 1'b1;
            if (rd_cnt == adcps_pkg::READ_LAST_EDGE - 1'b1)
            begin
                next_oe = 1'b0; // see RULE14
            end
            else
            begin
                next_dout = rd_sh[adcps_pkg::FRAME_W-1]; // see RULE13
                next_rd_sh = {rd_sh[adcps_pkg::FRAME_W-2:0], 1'b0};
            end
        end
    end

    // Low read sync holds the counter cleared, so a gated clock needs no idle edge
    always_ff @(posedge lnk.sclk or negedge lnk.read_frame_sync)
    begin
        if (!lnk.read_frame_sync) // see RULE11 RULE17 RULE10
        begin
            rd_cnt <= '0;
            rd_sh <= '0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            rd_cnt <= next_rd_cnt;
            rd_sh <= next_rd_sh;
            dout_q <= next_dout;
            oe_q <= next_oe;
        end
    end

    assign lnk.dout = dout_q;
    assign lnk.dout_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain: write shifter
    logic [adcps_pkg::EDGE_CNT_W-1:0] wf_cnt;
    logic [adcps_pkg::EDGE_CNT_W-1:0] next_wf_cnt;
    logic [adcps_pkg::CTRL_W-1:0] wr_sh;
    logic [adcps_pkg::CTRL_W-1:0] next_wr_sh;
    logic [adcps_pkg::EDGE_CNT_W-1:0] wr_cnt;
    logic [adcps_pkg::EDGE_CNT_W-1:0] next_wr_cnt;
    logic wr_done;
    logic next_wr_done;
    logic [adcps_pkg::CTRL_W-1:0] ctrl_hold;
    logic [adcps_pkg::CTRL_W-1:0] next_ctrl_hold;

    // Falling edges sample the input line, first bit is the MSB
    always_comb
    begin
        next_wf_cnt = wf_cnt;
        next_wr_sh = wr_sh;
        if (wf_cnt < adcps_pkg::WRITE_BITS) // see RULE12
        begin
            next_wf_cnt = wf_cnt + 1'b1;
            next_wr_sh = {wr_sh[adcps_pkg::CTRL_W-2:0], lnk.din}; // see RULE15 RULE20
        end
    end

    always_ff @(negedge lnk.sclk or posedge lnk.write_frame_sync)
    begin
        if (lnk.write_frame_sync) // see RULE11 RULE17
        begin
            wf_cnt <= '0;
            wr_sh <= '0;
        end
        else
        begin
            wf_cnt <= next_wf_cnt;
            wr_sh <= next_wr_sh;
        end
    end

    // Rising edges count toward the update edge
    always_comb
    begin
        next_wr_cnt = wr_cnt;
        next_wr_done = wr_done;
        next_ctrl_hold = ctrl_hold;
        if (wr_cnt < adcps_pkg::WRITE_UPD_EDGE)
        begin
            next_wr_cnt = wr_cnt + 1'b1;
            if (wr_cnt == adcps_pkg::WRITE_UPD_EDGE - 1'b1)
            begin
                next_wr_done = 1'b1; // see RULE16
                next_ctrl_hold = wr_sh;
            end
        end
    end

    always_ff @(posedge lnk.sclk or posedge lnk.write_frame_sync)
    begin
        if (lnk.write_frame_sync) // see RULE11
        begin
            wr_cnt <= '0;
            wr_done <= 1'b0;
        end
        else
        begin
            wr_cnt <= next_wr_cnt;
            wr_done <= next_wr_done;
        end
    end

    // Stays stable from the update edge until the next write frame
    always_ff @(posedge lnk.sclk)
    begin
        ctrl_hold <= next_ctrl_hold;
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: synchronised link levels
    logic trig_s;
    logic rfs_s;
    logic wdone_s;
    logic trig_p;
    logic wdone_p;

    adcps_sync2 #(
        .WIDTH(3),
        .INIT(3'h4)
    ) u_sync (
        .clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i({lnk.conversion_trigger_n, lnk.read_frame_sync, wr_done}),
        .sync_o({trig_s, rfs_s, wdone_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // System domain: power and conversion sequencing
    adcps_pkg::adcps_conv_e state;
    adcps_pkg::adcps_conv_e next_state;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    logic conv_pend;
    logic next_conv_pend;
    logic res_pend;
    logic next_res_pend;
    logic [adcps_pkg::RESULT_W-1:0] sample_q;
    logic [adcps_pkg::RESULT_W-1:0] next_sample;
    logic [adcps_pkg::RESULT_W-1:0] next_result;
    logic [adcps_pkg::CTRL_W-1:0] ctrl_q;
    logic [adcps_pkg::CTRL_W-1:0] next_ctrl;
    logic next_eoc;
    logic next_upd;
    logic trig_rise;
    logic trig_fall;

    assign trig_rise = trig_s & ~trig_p;
    assign trig_fall = ~trig_s & trig_p;

    // Sequencer; port logic above runs regardless of power state (see RULE9)
    always_comb
    begin
        next_state = state;
        next_tmr = tmr;
        next_conv_pend = conv_pend;
        next_res_pend = res_pend;
        next_sample = sample_q;
        next_result = result_q;
        next_ctrl = ctrl_q;
        next_eoc = 1'b0;
        next_upd = 1'b0;
        // Deferred result lands once the read sync drops
        if (res_pend && !rfs_s)
        begin
            next_result = sample_q;
            next_res_pend = 1'b0;
        end
        if (wdone_s && !wdone_p)
        begin
            next_ctrl = ctrl_hold;
            next_upd = 1'b1;
        end
        case (state)
            adcps_pkg::ADCPS_DOWN:
            begin
                if (trig_rise)
                begin
                    next_state = adcps_pkg::ADCPS_PWRUP; // see RULE2
                    next_tmr = PU_LOAD; // see RULE22
                    next_conv_pend = 1'b0;
                end
            end
            adcps_pkg::ADCPS_PWRUP:
            begin
                if (tmr != '0)
                begin
                    next_tmr = tmr - 1'b1;
                    next_conv_pend = conv_pend | trig_fall; // see RULE4
                end
                else if (conv_pend || trig_fall)
                begin
                    next_state = adcps_pkg::ADCPS_CONVERT; // see RULE4
                    next_tmr = CV_LOAD;
                    next_conv_pend = 1'b0;
                    next_sample = sample_i;
                end
                else
                begin
                    next_state = adcps_pkg::ADCPS_READY;
                end
            end
            adcps_pkg::ADCPS_READY:
            begin
                if (trig_fall)
                begin
                    next_state = adcps_pkg::ADCPS_CONVERT; // see RULE5
                    next_tmr = CV_LOAD; // see RULE22
                    next_sample = sample_i;
                end
            end
            default:
            begin
                if (tmr != '0)
                begin
                    next_tmr = tmr - 1'b1;
                end
                else
                begin
                    next_eoc = 1'b1;
                    // A read in progress keeps the older result (see RULE7)
                    if (rfs_s)
                    begin
                        next_res_pend = 1'b1;
                    end
                    else
                    begin
                        next_result = sample_q; // see RULE3
                        next_res_pend = 1'b0;
                    end
                    if (trig_s)
                    begin
                        next_state = adcps_pkg::ADCPS_READY; // see RULE19
                    end
                    else
                    begin
                        next_state = adcps_pkg::ADCPS_DOWN; // see RULE1 RULE3
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state <= adcps_pkg::ADCPS_DOWN;
            tmr <= '0;
            conv_pend <= 1'b0;
            res_pend <= 1'b0;
            sample_q <= '0;
            result_q <= '0;
            ctrl_q <= '0;
            eoc_o <= 1'b0;
            ctrl_upd_o <= 1'b0;
            trig_p <= 1'b1;
            wdone_p <= 1'b0;
        end
        else
        begin
            state <= next_state;
            tmr <= next_tmr;
            conv_pend <= next_conv_pend;
            res_pend <= next_res_pend;
            sample_q <= next_sample;
            result_q <= next_result;
            ctrl_q <= next_ctrl;
            eoc_o <= next_eoc;
            ctrl_upd_o <= next_upd;
            trig_p <= trig_s;
            wdone_p <= wdone_s;
        end
    end

    // Status straight from state registers
    assign result_o = result_q;
    assign ctrl_o = ctrl_q;
    assign powered_o = (state != adcps_pkg::ADCPS_DOWN);
    assign converting_o = (state == adcps_pkg::ADCPS_CONVERT);
endmodule : adcps_device
`default_nettype wire

// File: design/adcps_host.sv
// Host end: gated shift clock from a divider, frame syncs, trigger, read guard.
// Runs entirely on sys_clk_i; the link clock is made here.
`timescale 1ns/10ps
`default_nettype none
module adcps_host #(
    parameter int SCLK_HALF = adcps_pkg::SCLK_HALF,
    parameter int GUARD_CYCLES = adcps_pkg::PWRUP_CYCLES + adcps_pkg::CONV_CYCLES
) (
    // System clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link to converter
    adcps_link_if.host lnk,
    // Trigger level from user
    input wire logic trigger_n_i,
    // Transfer request
    input wire logic xfer_req_i,
    input wire logic xfer_read_i,
    input wire logic xfer_write_i,
    input wire logic [adcps_pkg::FRAME_W-1:0] xfer_wdata_i,
    output logic xfer_ready_o,
    // Transfer answer
    output logic xfer_done_o,
    output logic [adcps_pkg::FRAME_W-1:0] xfer_rdata_o,
    output logic read_hold_o
);
    localparam int DIV_W = $clog2(SCLK_HALF + 1);
    localparam int GRD_W = $clog2(GUARD_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(SCLK_HALF - 1);
    localparam logic [GRD_W-1:0] GRD_LOAD = GRD_W'(GUARD_CYCLES);

    adcps_pkg::adcps_host_e state;
    adcps_pkg::adcps_host_e next_state;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;
    logic [adcps_pkg::EDGE_CNT_W-1:0] edges;
    logic [adcps_pkg::EDGE_CNT_W-1:0] next_edges;
    logic sclk_q;
    logic next_sclk;
    logic rfs_q;
    logic next_rfs;
    logic wfs_q;
    logic next_wfs;
    logic din_q;
    logic next_din;
    logic trig_q;
    logic [GRD_W-1:0] guard;
    logic [GRD_W-1:0] next_guard;
    logic [adcps_pkg::FRAME_W-1:0] wsh;
    logic [adcps_pkg::FRAME_W-1:0] next_wsh;
    logic [adcps_pkg::FRAME_W-1:0] rsh;
    logic [adcps_pkg::FRAME_W-1:0] next_rsh;
    logic [adcps_pkg::FRAME_W-1:0] next_rdata;
    logic next_done;
    logic dout_s;

    // Data line changes on the device clock; resync before sampling
    adcps_sync2 #(
        .WIDTH(1),
        .INIT(1'h0)
    ) u_sync (
        .clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(lnk.dout_line),
        .sync_o(dout_s)
    );

    // Reads wait out power-up plus conversion after each trigger fall
    assign xfer_ready_o = (state == adcps_pkg::ADCPS_H_IDLE)
                          && !(xfer_read_i && (guard != '0)); // see RULE8
    assign read_hold_o = (guard != '0);

    always_comb
    begin
        next_state = state;
        next_div = div;
        next_edges = edges;
        next_sclk = sclk_q;
        next_rfs = rfs_q;
        next_wfs = wfs_q;
        next_din = din_q;
        next_wsh = wsh;
        next_rsh = rsh;
        next_rdata = xfer_rdata_o;
        next_done = 1'b0;
        next_guard = guard;
        if (trig_q && !trigger_n_i)
        begin
            next_guard = GRD_LOAD;
        end
        else if (guard != '0)
        begin
            next_guard = guard - 1'b1;
        end
        if (div != '0)
        begin
            next_div = div - 1'b1;
        end
        case (state)
            adcps_pkg::ADCPS_H_IDLE:
            begin
                if (xfer_req_i && xfer_ready_o)
                begin
                    next_state = adcps_pkg::ADCPS_H_LEAD;
                    next_div = DIV_LOAD;
                    next_edges = '0;
                    next_rfs = xfer_read_i;
                    next_wfs = !xfer_write_i;
                    next_din = xfer_wdata_i[adcps_pkg::FRAME_W-1]; // see RULE20
                    next_wsh = {xfer_wdata_i[adcps_pkg::FRAME_W-2:0], 1'b0};
                end
            end
            adcps_pkg::ADCPS_H_LEAD:
            begin
                if (div == '0)
                begin
                    next_state = adcps_pkg::ADCPS_H_CLK;
                    next_div = DIV_LOAD;
                    next_sclk = 1'b1; // see RULE18
                    next_edges = edges + 1'b1;
                end
            end
            adcps_pkg::ADCPS_H_CLK:
            begin
                if (div == '0)
                begin
                    next_div = DIV_LOAD;
                    next_sclk = !sclk_q;
                    if (sclk_q)
                    begin
                        next_rsh = {rsh[adcps_pkg::FRAME_W-2:0], dout_s};
                        if (edges == adcps_pkg::HOST_EDGES) // see RULE14 RULE16
                        begin
                            next_state = adcps_pkg::ADCPS_H_TAIL;
                            next_rfs = 1'b0;
                            next_wfs = 1'b1;
                        end
                    end
                    else
                    begin
                        next_edges = edges + 1'b1;
                        next_din = wsh[adcps_pkg::FRAME_W-1];
                        next_wsh = {wsh[adcps_pkg::FRAME_W-2:0], 1'b0};
                    end
                end
            end
            default:
            begin
                if (div == '0)
                begin
                    next_state = adcps_pkg::ADCPS_H_IDLE;
                    next_done = 1'b1;
                    next_rdata = rsh;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            state <= adcps_pkg::ADCPS_H_IDLE;
            div <= '0;
            edges <= '0;
            sclk_q <= 1'b0;
            rfs_q <= 1'b0;
            wfs_q <= 1'b1;
            din_q <= 1'b0;
            trig_q <= 1'b1;
            guard <= '0;
            wsh <= '0;
            rsh <= '0;
            xfer_rdata_o <= '0;
            xfer_done_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            div <= next_div;
            edges <= next_edges;
            sclk_q <= next_sclk;
            rfs_q <= next_rfs;
            wfs_q <= next_wfs;
            din_q <= next_din;
            trig_q <= trigger_n_i;
            guard <= next_guard;
            wsh <= next_wsh;
            rsh <= next_rsh;
            xfer_rdata_o <= next_rdata;
            xfer_done_o <= next_done;
        end
    end

    // Pins straight from flops
    assign lnk.sclk = sclk_q;
    assign lnk.read_frame_sync = rfs_q;
    assign lnk.write_frame_sync = wfs_q;
    assign lnk.din = din_q;
    assign lnk.conversion_trigger_n = trig_q;
endmodule : adcps_host
`default_nettype wire

// File: design/adcps_link_if.sv
// Five-wire serial link plus conversion trigger between host and converter.
// The testbench instantiates this and joins both ends to it.
`timescale 1ns/10ps
`default_nettype none
interface adcps_link_if;
    logic sclk;
    logic read_frame_sync;
    logic write_frame_sync;
    logic din;
    logic dout;
    logic dout_oe;
    logic conversion_trigger_n;
    logic dout_line;

    // Undriven data line reads as low
    assign dout_line = dout_oe ? dout : 1'b0;

    modport device (
        input sclk,
        input read_frame_sync,
        input write_frame_sync,
        input din,
        input conversion_trigger_n,
        output dout,
        output dout_oe
    );

    modport host (
        output sclk,
        output read_frame_sync,
        output write_frame_sync,
        output din,
        output conversion_trigger_n,
        input dout_line
    );
endinterface : adcps_link_if
`default_nettype wire

// File: design/adcps_pkg.sv
// Shared constants and types for the converter serial port and its host.
// Assumes a 250 MHz system clock on both ends.
package adcps_pkg;
    // System clock period and documented intervals
    localparam int SYS_PERIOD_NS = 4;
    localparam int PWRUP_TIME_NS = 1500;
    localparam int CONV_TIME_NS = 2300;
    // Least times round up to whole cycles
    localparam int PWRUP_CYCLES = (PWRUP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int CONV_CYCLES = (CONV_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    // Word and frame layout
    localparam int RESULT_W = 10;
    localparam int FRAME_W = 16;
    localparam int RESULT_LSB = FRAME_W - RESULT_W;
    localparam int CTRL_W = 12;
    // Shift clock edge counts
    localparam int EDGE_CNT_W = 5;
    localparam logic [EDGE_CNT_W-1:0] READ_LAST_EDGE = 5'h0B;
    localparam logic [EDGE_CNT_W-1:0] WRITE_UPD_EDGE = 5'h0D;
    localparam logic [EDGE_CNT_W-1:0] WRITE_BITS = 5'h0C;
    localparam logic [EDGE_CNT_W-1:0] HOST_EDGES = 5'h10;
    // Host shift clock half period in system cycles
    localparam int SCLK_HALF = 16;

    typedef enum logic [1:0] {
        ADCPS_DOWN = 2'b00,
        ADCPS_PWRUP = 2'b01,
        ADCPS_READY = 2'b10,
        ADCPS_CONVERT = 2'b11
    } adcps_conv_e;

    typedef enum logic [1:0] {
        ADCPS_H_IDLE = 2'b00,
        ADCPS_H_LEAD = 2'b01,
        ADCPS_H_CLK = 2'b10,
        ADCPS_H_TAIL = 2'b11
    } adcps_host_e;
endpackage : adcps_pkg

// File: design/adcps_sync2.sv
// Two-flop level synchroniser, one lane per bit.
// Inputs may come from any clock domain or a pin.
`timescale 1ns/10ps
`default_nettype none
module adcps_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // First stage feeds only the second
    always_comb
    begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta <= INIT;
            sync_o <= INIT;
        end
        else
        begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule : adcps_sync2
`default_nettype wire

// File: testbench/adcps_link_assertions.sv
// Checker for the host-converter serial link.
// Sees only link signals plus the system clock and its reset.
`timescale 1ns/10ps
`default_nettype none
module adcps_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link signals
    input wire logic sclk,
    input wire logic read_frame_sync,
    input wire logic write_frame_sync,
    input wire logic conversion_trigger_n,
    input wire logic dout_oe
);
    logic sclk_q;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    // Shift clock rises in the open frame; no frame clears it
    always_comb
    begin
        next_cnt = cnt;
        if (!read_frame_sync && write_frame_sync)
            next_cnt = 5'h00;
        else if (sclk && !sclk_q)
            next_cnt = cnt + 5'h01;
    end
    // Registers only
    always_ff @(posedge sys_clk_i)
    begin
        sclk_q <= sclk;
        cnt <= srst_i ? 5'h00 : next_cnt;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////
    // Count is sampled before the edge that sees a rise, hence one behind
    property p_idle; !read_frame_sync |-> !dout_oe; endproperty
    a_idle: assert property (p_idle) else $error("oe outside frame");
    property p_start; $rose(dout_oe) |-> $rose(sclk) && cnt == 5'h00; endproperty
    a_start: assert property (p_start) else $error("oe start");
    property p_hold; read_frame_sync && cnt inside {[5'h01:5'h09]} |-> dout_oe; endproperty
    a_hold: assert property (p_hold) else $error("oe dropped");
    property p_end; $fell(dout_oe) && read_frame_sync |-> $rose(sclk) && cnt == 5'h0A; endproperty
    a_end: assert property (p_end) else $error("oe end");
    property p_ign; read_frame_sync && cnt > 5'h0A |-> !dout_oe; endproperty
    a_ign: assert property (p_ign) else $error("oe after count");
    property p_rd; $fell(read_frame_sync) |-> cnt == 5'h10; endproperty
    a_rd: assert property (p_rd) else $error("read clocks");
    property p_wr; $rose(write_frame_sync) |-> cnt == 5'h10; endproperty
    a_wr: assert property (p_wr) else $error("write clocks");
    property p_gate; !read_frame_sync && write_frame_sync |-> !sclk; endproperty
    a_gate: assert property (p_gate) else $error("sclk free");
    property p_guard; $fell(conversion_trigger_n) |-> (!$rose(read_frame_sync)) [*8]; endproperty
    a_guard: assert property (p_guard) else $error("read too soon");
endmodule : adcps_chk
`default_nettype wire

// File: testbench/testbench.sv
// Bench joining host and converter over the link.
// Uses short interval parameters to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic sys_clk_i;
    logic srst_i;
    logic trigger_n_i;
    logic xfer_req_i;
    logic xfer_read_i;
    logic xfer_write_i;
    logic [15:0] xfer_wdata_i;
    logic xfer_ready_o;
    logic xfer_done_o;
    logic [15:0] xfer_rdata_o;
    logic [9:0] sample_i;
    logic [9:0] result_o;
    logic eoc_o;
    logic powered_o;
    logic [11:0] ctrl_o;
    logic converting_o;
    int n_mismatch = 0;
    int compares = 0;
    int n;
    adcps_link_if lnk ();
    adcps_device #(.PWRUP_CYCLES(8), .CONV_CYCLES(12)) u_adcps_device (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .lnk(lnk), .sample_i(sample_i),
        .result_o(result_o), .eoc_o(eoc_o), .powered_o(powered_o), .converting_o(converting_o),
        .ctrl_o(ctrl_o), .ctrl_upd_o());
    adcps_host #(.SCLK_HALF(4), .GUARD_CYCLES(24)) u_adcps_host (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .lnk(lnk), .trigger_n_i(trigger_n_i),
        .xfer_req_i(xfer_req_i), .xfer_read_i(xfer_read_i), .xfer_write_i(xfer_write_i),
        .xfer_wdata_i(xfer_wdata_i), .xfer_ready_o(xfer_ready_o), .xfer_done_o(xfer_done_o),
        .xfer_rdata_o(xfer_rdata_o), .read_hold_o());
    adcps_chk u_adcps_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sclk(lnk.sclk),
        .read_frame_sync(lnk.read_frame_sync), .write_frame_sync(lnk.write_frame_sync),
        .conversion_trigger_n(lnk.conversion_trigger_n), .dout_oe(lnk.dout_oe));
    ////////////////////////////////////////
    task report_and_stop();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // Inputs move just after the edge to avoid sampling races
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait; a hang ends the run as a failure
    task automatic wait_hi(ref logic s, output int c);
        c = 0;
        while (s !== 1'b1)
        begin
            tick(1);
            c++;
            if (c > 3000)
            begin
                n_mismatch++;
                report_and_stop();
            end
        end
    endtask : wait_hi
    task xfer(input logic rd, input logic [15:0] wd, input logic [15:0] exp);
        int c;
        xfer_read_i = rd;
        xfer_write_i = !rd;
        xfer_wdata_i = wd;
        tick(1); // Ready settles on the new read flag first
        xfer_req_i = 1'b1;
        wait_hi(xfer_ready_o, c);
        tick(1);
        xfer_req_i = 1'b0;
        wait_hi(xfer_done_o, c);
        if (rd)
            chk(xfer_rdata_o, exp);
    endtask : xfer
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Main sequence
    initial
    begin
        srst_i = 1'b1;
        trigger_n_i = 1'b0;
        xfer_req_i = 1'b0;
        xfer_read_i = 1'b0;
        xfer_write_i = 1'b0;
        xfer_wdata_i = 16'h0000;
        sample_i = 10'h2A5;
        tick(10);
        srst_i = 1'b0;
        tick(10);
        chk(16'(powered_o), 16'h0000);
        xfer(1'b0, 16'hA5C3, 16'h0000);
        chk(16'(ctrl_o), 16'h0A5C);
        $display("test write done");
        trigger_n_i = 1'b1;
        tick(2);
        trigger_n_i = 1'b0;
        wait_hi(eoc_o, n);
        chk(16'(n >= 18), 16'h0001);
        chk(16'(result_o), 16'h02A5);
        tick(3);
        chk(16'(powered_o), 16'h0000);
        xfer(1'b1, 16'h0000, 16'hA940);
        $display("test early fall done");
        sample_i = 10'h1C7;
        trigger_n_i = 1'b1;
        tick(20);
        chk(16'(powered_o), 16'h0001);
        fork
            xfer(1'b1, 16'h0000, 16'hA940);
            begin
                tick(10);
                trigger_n_i = 1'b0;
                tick(4);
                chk(16'(converting_o), 16'h0001);
                trigger_n_i = 1'b1;
                wait_hi(eoc_o, n);
                chk(16'(n >= 8 && n <= 14), 16'h0001);
            end
        join
        chk(16'(powered_o), 16'h0001);
        chk(16'(result_o), 16'h01C7);
        xfer(1'b1, 16'h0000, 16'h71C0);
        $display("test late fall done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
